// >>> hdl/faps_consts.svh
/*
 * Offsets, field positions, reset values and the S5 sleep code of the
 * function active and power status register bank.
 * Assumes inclusion by bare name from any design file.
 */
`ifndef FAPS_CONSTS_SVH
`define FAPS_CONSTS_SVH

`define FAPS_STATUS_OFFSET 8'h00
`define FAPS_ADDR_W 8
`define FAPS_DATA_W 32
`define FAPS_STATUS_RESET 32'h0000_0000
`define FAPS_UNMAPPED_DATA 32'h0000_0000

`define FAPS_BIT_P1_ACTIVE 10
`define FAPS_BIT_P1_AUX 9
`define FAPS_BIT_P1_PRESENT 8
`define FAPS_PS1_LSB 6
`define FAPS_BIT_P0_ACTIVE 4
`define FAPS_BIT_P0_AUX 3
`define FAPS_BIT_P0_PRESENT 2
`define FAPS_PS0_LSB 0

`define FAPS_NVM_PCI_DIS_BIT 10
`define FAPS_NVM_DIS_BIT 11

`define FAPS_SLEEP_S5 3'h5

`endif

// >>> hdl/faps_pkg.sv
/*
 * Types shared by the status register bank.
 * Assumes nothing of its surroundings.
 */
package faps_pkg;

    // device flavour the bank is built for
    typedef enum logic [1:0] {
        FAPS_VAR_DUAL_CTRL,
        FAPS_VAR_CHIPSET,
        FAPS_VAR_SINGLE
    } faps_variant_e;

    typedef logic [1:0] faps_pstate_t;

    localparam faps_pstate_t FAPS_PS_DR = 2'h0;
    localparam faps_pstate_t FAPS_PS_D0U = 2'h1;
    localparam faps_pstate_t FAPS_PS_D0A = 2'h2;
    localparam faps_pstate_t FAPS_PS_D3 = 2'h3;

endpackage

// >>> hdl/faps_port_status.sv
/*
 * Per-port status slice: presence, active and power state as they
 * land in the status word.
 * Assumes inputs synchronous to core_clk.
 */
`timescale 1ns/1ps
`include "faps_consts.svh"

module faps_port_status
    import faps_pkg::*;
#(
    parameter faps_variant_e VARIANT = FAPS_VAR_DUAL_CTRL,
    parameter bit IS_PORT1 = 1'b0
) (
    // config
    input wire logic strap_en,
    input wire logic [15:0] nvm_word,
    input wire logic aux_en,
    input wire faps_pstate_t pstate,
    // slice
    output logic present,
    output logic active,
    output logic aux,
    output faps_pstate_t ps
);
    logic exists;

    assign exists = !(IS_PORT1 && VARIANT == FAPS_VAR_SINGLE);

    always_comb begin
        if (!IS_PORT1 && VARIANT == FAPS_VAR_SINGLE) begin
            present = 1'b1;
        end else if (!exists) begin
            present = 1'b0;
        end else if (!IS_PORT1 && VARIANT == FAPS_VAR_CHIPSET) begin
            present = !nvm_word[`FAPS_NVM_DIS_BIT];
        end else begin
            present = strap_en;
        end
    end

    // active only exists on the chipset variant
    assign active = (VARIANT == FAPS_VAR_CHIPSET) &&
        !nvm_word[`FAPS_NVM_PCI_DIS_BIT] && present;
    assign aux = exists && aux_en;
    assign ps = exists ? pstate : FAPS_PS_DR;

endmodule

// >>> hdl/faps_read_port.sv
/*
 * Read-only register port: decodes the address, returns the status
 * word a cycle after the read strobe, drops writes.
 * Assumes one-cycle strobes synchronous to core_clk.
 */
`timescale 1ns/1ps
`include "faps_consts.svh"

module faps_read_port #(
    parameter int AW = `FAPS_ADDR_W,
    parameter int DW = `FAPS_DATA_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bus
    input wire logic [AW-1:0] addr,
    input wire logic rd_stb,
    input wire logic [DW-1:0] status,
    output logic [DW-1:0] rd_data
);
    if (AW < 2 || DW != 32) begin : g_bad_width
        $error("faps_read_port: unsupported width");
    end

    function automatic logic hit(input logic [AW-1:0] a);
        hit = (a == AW'(`FAPS_STATUS_OFFSET));
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data <= `FAPS_STATUS_RESET;
        end else if (rd_stb && hit(addr)) begin
            rd_data <= status;
        end else if (rd_stb) begin
            rd_data <= `FAPS_UNMAPPED_DATA;
        end
    end

endmodule

// >>> hdl/faps_status_bank.sv
/*
 * Function active and power status register bank, top level.
 * Holds the status word, fed from straps, nonvolatile words and the
 * power management logic, and read over a plain strobe port.
 * Assumes all inputs synchronous to core_clk at 10 MHz.
 */
// Implementation choices: the strobed register port and the placing of the registers.
// Overview of operation
// - bit 10 is port 1 active, chipset variant only: nvm pci-disable clear and present
// - bit 9 mirrors function 1 aux power enable
// - without second port, bits 9 and 7:6 read zero
// - bit 8 is port 1 presence from its enable strap
// - single-port variant holds port 1 presence at zero
// - bits 7:6 are function 1 power state DR,D0u,D0a,D3
// - bit 4 is port 0 active, chipset variant only: nvm pci-disable clear and present
// - bit 3 mirrors function 0 aux power enable
// - bit 2 is port 0 presence, strap on dual controller
// - chipset variant: port 0 present when nvm disable bit clear
// - single-port variant holds port 0 presence at one
// - bits 1:0 are function 0 power state, same coding
// - fields undefined while system sleeps in S5
`timescale 1ns/1ps
`include "faps_consts.svh"

module faps_status_bank
    import faps_pkg::*;
#(
    parameter faps_variant_e VARIANT = FAPS_VAR_CHIPSET,
    parameter int AW = `FAPS_ADDR_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // straps and nvm words
    input wire logic port0_strap_en,
    input wire logic port1_strap_en,
    input wire logic [15:0] nvm_word_10,
    input wire logic [15:0] nvm_word_20,
    // power management
    input wire logic func0_aux_en,
    input wire logic func1_aux_en,
    input wire faps_pstate_t func0_pstate,
    input wire faps_pstate_t func1_pstate,
    input wire logic [2:0] sleep_state,
    // decoded status
    output logic port0_present,
    output logic port1_present,
    output logic status_valid
);
    if (AW < 2 || AW > 32) begin : g_bad_aw
        $error("faps_status_bank: AW out of range");
    end

    logic [31:0] status_r;
    logic [31:0] status_nxt;
    logic p0_present, p0_active, p0_aux;
    logic p1_present, p1_active, p1_aux;
    faps_pstate_t p0_ps, p1_ps;
    logic unused_wr;

    // writes carry no effect at all
    assign unused_wr = reg_wr ^ (|reg_wdata);

    faps_port_status #(.VARIANT(VARIANT), .IS_PORT1(1'b0)) u_port0 (
        .strap_en(port0_strap_en),
        .nvm_word(nvm_word_20),
        .aux_en(func0_aux_en),
        .pstate(func0_pstate),
        .present(p0_present),
        .active(p0_active),
        .aux(p0_aux),
        .ps(p0_ps)
    );

    faps_port_status #(.VARIANT(VARIANT), .IS_PORT1(1'b1)) u_port1 (
        .strap_en(port1_strap_en),
        .nvm_word(nvm_word_10),
        .aux_en(func1_aux_en),
        .pstate(func1_pstate),
        .present(p1_present),
        .active(p1_active),
        .aux(p1_aux),
        .ps(p1_ps)
    );

    always_comb begin
        status_nxt = `FAPS_STATUS_RESET;
        status_nxt[`FAPS_BIT_P1_ACTIVE] = p1_active;
        status_nxt[`FAPS_BIT_P1_AUX] = p1_aux;
        status_nxt[`FAPS_BIT_P1_PRESENT] = p1_present;
        status_nxt[`FAPS_PS1_LSB +: 2] = p1_ps;
        status_nxt[`FAPS_BIT_P0_ACTIVE] = p0_active;
        status_nxt[`FAPS_BIT_P0_AUX] = p0_aux;
        status_nxt[`FAPS_BIT_P0_PRESENT] = p0_present;
        status_nxt[`FAPS_PS0_LSB +: 2] = p0_ps;
    end

    // one register stage; status lags inputs by a cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_r <= `FAPS_STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // in S5 contents are not trustworthy; flag it for firmware
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_valid <= 1'b0;
        end else begin
            status_valid <= (sleep_state != `FAPS_SLEEP_S5);
        end
    end

    assign port0_present = status_r[`FAPS_BIT_P0_PRESENT];
    assign port1_present = status_r[`FAPS_BIT_P1_PRESENT];

    faps_read_port #(.AW(AW), .DW(32)) u_rd (
        .core_clk(core_clk),
        .rst(rst),
        .addr(reg_addr),
        .rd_stb(reg_rd),
        .status(status_r),
        .rd_data(reg_rdata)
    );

    // live fields; the past-reset guard skips the edge that still
    // shows the cleared word after release
    AST_P1_ACTIVE: assert property (@(posedge core_clk) disable iff (rst)
        status_r[`FAPS_BIT_P1_ACTIVE] |-> status_r[`FAPS_BIT_P1_PRESENT])
        else $error("port1 active without presence");

    AST_P0_ACTIVE: assert property (@(posedge core_clk) disable iff (rst)
        status_r[`FAPS_BIT_P0_ACTIVE] |-> status_r[`FAPS_BIT_P0_PRESENT])
        else $error("port0 active without presence");

    AST_AUX1: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT != FAPS_VAR_SINGLE) |->
        status_r[`FAPS_BIT_P1_AUX] == $past(func1_aux_en))
        else $error("aux1 mirror wrong");

    AST_AUX0: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) |-> status_r[`FAPS_BIT_P0_AUX] == $past(func0_aux_en))
        else $error("aux0 mirror wrong");

    AST_SINGLE_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_SINGLE) |->
        status_r[10:6] == 5'h00 && status_r[2])
        else $error("single variant fixed bits wrong");

    AST_PS1: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT != FAPS_VAR_SINGLE) |->
        status_r[7:6] == $past(func1_pstate))
        else $error("func1 power state wrong");

    AST_PS0: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) |-> status_r[1:0] == $past(func0_pstate))
        else $error("func0 power state wrong");

    AST_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        status_r[31:11] == 21'h0 && status_r[5] == 1'b0)
        else $error("reserved bits set");

    AST_READ: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == AW'(`FAPS_STATUS_OFFSET) |=>
        reg_rdata == $past(status_r))
        else $error("read data wrong");

    AST_CHIP_P0: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_CHIPSET) |->
        status_r[2] == !$past(nvm_word_20[`FAPS_NVM_DIS_BIT]))
        else $error("chipset port0 presence wrong");

    AST_S5: assert property (@(posedge core_clk) disable iff (rst)
        sleep_state == `FAPS_SLEEP_S5 |=> !status_valid)
        else $error("valid high in S5");

    AST_S5_EXIT: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && sleep_state != `FAPS_SLEEP_S5 |=> status_valid)
        else $error("valid low outside S5");

    AST_P1_ACT_SRC: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_CHIPSET) |->
        status_r[10] == (!$past(nvm_word_10[10]) && $past(port1_strap_en)))
        else $error("port1 active source wrong");

    AST_P0_ACT_SRC: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_CHIPSET) |->
        status_r[4] == (!$past(nvm_word_20[10]) && !$past(nvm_word_20[11])))
        else $error("port0 active source wrong");

    AST_P1_ACT_CLR: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_CHIPSET) &&
        $past(nvm_word_10[`FAPS_NVM_PCI_DIS_BIT]) |-> !status_r[10])
        else $error("port1 active despite nvm flag");

    AST_P0_ACT_CLR: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_CHIPSET) &&
        $past(nvm_word_20[`FAPS_NVM_PCI_DIS_BIT]) |-> !status_r[4])
        else $error("port0 active despite nvm flag");

    AST_P1_ACT_STRAP: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_CHIPSET) &&
        !$past(port1_strap_en) |-> !status_r[10])
        else $error("port1 active without strap");

    AST_P0_DIS: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_CHIPSET) &&
        $past(nvm_word_20[`FAPS_NVM_DIS_BIT]) |-> !status_r[2] && !status_r[4])
        else $error("port0 present despite disable");

    AST_P0_CHIP_ONE: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_CHIPSET) &&
        !$past(nvm_word_20[`FAPS_NVM_DIS_BIT]) |-> status_r[2])
        else $error("port0 absent with disable clear");

    AST_P1_PRES_SRC: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT != FAPS_VAR_SINGLE) |->
        status_r[8] == $past(port1_strap_en))
        else $error("port1 presence not from strap");

    AST_P0_PRES_DUAL: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_DUAL_CTRL) |->
        status_r[2] == $past(port0_strap_en))
        else $error("port0 presence not from strap");

    // per-variant fixed fields, then the presence outputs
    AST_P0_PRES_ONE: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) && (VARIANT == FAPS_VAR_SINGLE) |->
        status_r[`FAPS_BIT_P0_PRESENT])
        else $error("single port0 presence not one");

    AST_P1_PRES_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        (VARIANT == FAPS_VAR_SINGLE) |->
        !status_r[`FAPS_BIT_P1_PRESENT])
        else $error("single port1 presence not zero");

    AST_SINGLE_RSVD: assert property (@(posedge core_clk) disable iff (rst)
        (VARIANT == FAPS_VAR_SINGLE) |->
        !status_r[`FAPS_BIT_P1_AUX] && status_r[7:6] == 2'h0)
        else $error("single reserved bits set");

    AST_NOACT_DUAL: assert property (@(posedge core_clk) disable iff (rst)
        (VARIANT == FAPS_VAR_DUAL_CTRL) |->
        !status_r[`FAPS_BIT_P1_ACTIVE] && !status_r[`FAPS_BIT_P0_ACTIVE])
        else $error("dual active bits set");

    AST_NOACT_SINGLE: assert property (@(posedge core_clk) disable iff (rst)
        (VARIANT == FAPS_VAR_SINGLE) |->
        !status_r[`FAPS_BIT_P1_ACTIVE] && !status_r[`FAPS_BIT_P0_ACTIVE])
        else $error("single active bits set");

    AST_PORT0_OUT: assert property (@(posedge core_clk) disable iff (rst)
        port0_present == status_r[`FAPS_BIT_P0_PRESENT])
        else $error("port0 presence output wrong");

    AST_PORT1_OUT: assert property (@(posedge core_clk) disable iff (rst)
        port1_present == status_r[`FAPS_BIT_P1_PRESENT])
        else $error("port1 presence output wrong");

    // bus and reset
    AST_RD_UNMAPPED: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr != AW'(`FAPS_STATUS_OFFSET) |=>
        reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    AST_RD_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");

    AST_WR_IGNORED: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && !reg_rd |=> $stable(reg_rdata))
        else $error("write changed read data");

    // no disable here: reset itself is what is checked
    AST_RESET_CLEAR: assert property (@(posedge core_clk)
        rst |=> status_r == 32'h0000_0000 && reg_rdata == 32'h0000_0000)
        else $error("reset left status set");

    AST_RESET_OUTS: assert property (@(posedge core_clk)
        rst |=> !port0_present && !port1_present && !status_valid)
        else $error("reset left outputs set");

endmodule

// >>> tb/tb_faps_status_bank.sv
/*
 * Self-checking bench for the status register bank, built three times:
 * chipset, single-port and dual-controller flavours on shared inputs.
 * Assumes the design files compiled before it; no partner model.
 */
`timescale 1ns/1ps

module tb_faps_status_bank;
    import faps_pkg::*;

    logic core_clk, rst, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_s, rd_d;
    logic port0_strap_en, port1_strap_en, func0_aux_en, func1_aux_en;
    logic [15:0] nvm_word_10, nvm_word_20;
    faps_pstate_t func0_pstate, func1_pstate;
    logic [2:0] sleep_state;
    logic port0_present, port1_present, status_valid, p0_s, p1_s;
    int fail_count, num_checks, cyc;
    // row: inputs {s0,s1,n10,n20a,n20b,a0,a1,ps0,ps1}, chipset bits 10:0
    logic [21:0] rows [4] = '{{11'h221, 11'h55c}, {11'h45b, 11'h2c2},
        {11'h3b6, 11'h38d}, {11'h00c, 11'h017}};
    logic [10:0] r;

    faps_status_bank #(.VARIANT(FAPS_VAR_CHIPSET)) dut (.*);
    faps_status_bank #(.VARIANT(FAPS_VAR_SINGLE)) dut_s (.*,
        .reg_rdata(rd_s), .port0_present(p0_s), .port1_present(p1_s),
        .status_valid());
    faps_status_bank #(.VARIANT(FAPS_VAR_DUAL_CTRL)) dut_d (.*,
        .reg_rdata(rd_d), .port0_present(), .port1_present(),
        .status_valid());

    task automatic close_out;
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask

    // one-cycle read strobe; returns inside the answer cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // hang guard, well above the sixty-odd cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            close_out;
        end
    end

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {port0_strap_en, port1_strap_en, func0_aux_en, func1_aux_en} = '1;
        nvm_word_10 = 16'h0000;
        nvm_word_20 = 16'h0000;
        func0_pstate = FAPS_PS_D3;
        func1_pstate = FAPS_PS_D0A;
        sleep_state = 3'h0;
        repeat (15) @(posedge core_clk);
        #1 chk(reg_rdata, 32'h0000_0000);
        chk({port0_present, port1_present, status_valid}, 32'h0);
        @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            r = rows[i][21:11];
            @(posedge core_clk);
            port0_strap_en <= r[10];
            port1_strap_en <= r[9];
            // other nvm bits set so only the flag bits may matter
            nvm_word_10 <= 16'h52a5 | {5'h00, r[8], 10'h000};
            nvm_word_20 <= 16'h52a5 | {4'h0, r[6], r[7], 10'h000};
            func0_aux_en <= r[5];
            func1_aux_en <= r[4];
            func0_pstate <= r[3:2];
            func1_pstate <= r[1:0];
            repeat (2) @(posedge core_clk);
            rd(8'h00, {21'h0, rows[i][10:0]});
            chk(rd_s, {24'h0, 4'h0, r[5], 1'b1, r[3:2]});
            chk(rd_d, {21'h0, 1'b0, r[4], r[9], r[1:0], 2'h0, r[5], r[10],
                r[3:2]});
            chk({port0_present, port1_present}, {rows[i][2], rows[i][8]});
            chk({p0_s, p1_s}, 32'h2);
        end
        // writes must leave the word untouched
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h00;
        reg_wdata <= 32'hffff_ffff;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        rd(8'h00, 32'h0000_0017);
        rd(8'h04, 32'h0000_0000);
        // back-to-back reads, mapped then unmapped
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= 8'h00;
        @(posedge core_clk);
        reg_addr <= 8'h04;
        #1 chk(reg_rdata, 32'h0000_0017);
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, 32'h0000_0000);
        @(posedge core_clk);
        sleep_state <= 3'h5;
        repeat (2) @(posedge core_clk);
        #1 chk({31'h0, status_valid}, 32'h0);
        @(posedge core_clk);
        sleep_state <= 3'h3;
        repeat (2) @(posedge core_clk);
        #1 chk({31'h0, status_valid}, 32'h1);
        // reset in mid-run clears, then live data returns
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk(reg_rdata, 32'h0000_0000);
        chk({port0_present, port1_present, status_valid}, 32'h0);
        @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(8'h00, 32'h0000_0017);
        close_out;
    end
endmodule
